/* rtl/cacf_pkg.sv */
// Purpose: shared constants and carriers for the counter array control register
// Assumes: 8-bit special-function register space, one core clock
// Notes:   bit positions and the register address are defined here; the bench and checker repeat some as literals
package cacf_pkg;
	localparam logic [7:0] CTRL_ADDR    = 8'hd8;
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam int         OVF_BIT      = 7;
	localparam int         RUN_BIT      = 6;
	localparam int         MOD2_BIT     = 2;
	localparam int         MOD1_BIT     = 1;
	localparam int         MOD0_BIT     = 0;
	localparam int         NUM_MODULES  = 3;
	localparam logic [7:0] RSVD_MASK    = 8'h38;
	localparam logic [15:0] CNT_RESET   = 16'h0000;
	localparam logic [15:0] CNT_MAX     = 16'hffff;

	// special-function register access from the core
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cacf_sfr_req_t;

	// overflow and per-module interrupt enables
	typedef struct packed {
		logic                   ovf_ie;
		logic [NUM_MODULES-1:0] mod_ie;
	} cacf_irq_en_t;
endpackage

/* rtl/cacf_ctrl.sv */
// Purpose: control/status register of a three-module counter array
// Assumes: core accesses are synchronous to clk_i; module events are one-cycle pulses
// Notes:   flags are sticky; only a software write of 0 clears them
// Operation
// - run bit six starts and stops counter
// - module flag sets on match or capture
// - module flags at bits two, one, zero
// - enabled set module flag raises interrupt
module cacf_ctrl
	import cacf_pkg::*;
#(
	parameter int CNT_WIDTH = 16,
	parameter int MODULES   = NUM_MODULES
)
(
	input  wire logic                    clk_i,
	input  wire logic                    sys_rst_i,
	input  wire cacf_pkg::cacf_sfr_req_t sfr_req_i,
	input  wire cacf_pkg::cacf_irq_en_t  irq_en_i,
	input  wire logic                    count_tick_i,
	input  wire logic [2:0]              mod_event_i,
	output logic [7:0]                   sfr_rdata_o,
	output logic                         sfr_rvalid_o,
	output logic                         counter_run_o,
	output logic [15:0]                  counter_value_o,
	output logic                         counter_wrap_o,
	output logic                         irq_o
);
	import cacf_pkg::*;

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	// the register layout has room for exactly three module flags
	if (MODULES != 3) begin : g_bad_modules
		$error("cacf_ctrl serves exactly three modules");
	end

	// overflow is defined at the 16-bit wrap only
	if (CNT_WIDTH != 16) begin : g_bad_width
		$error("cacf_ctrl serves a 16-bit counter only");
	end

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic        counter_run_control;
	logic        counter_overflow_flag;
	logic [2:0]  module_event_flag;
	logic [15:0] count;
	logic [15:0] next_count;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire       hit;
	wire       wr_hit;
	wire       rd_hit;
	wire [7:0] wd;
	wire [2:0] wr_mod;

	assign hit    = sfr_req_i.addr == CTRL_ADDR;
	assign wr_hit = sfr_req_i.wr && hit;
	assign rd_hit = sfr_req_i.rd && hit;
	assign wd     = sfr_req_i.wdata;
	// reserved bits of the written byte are dropped here
	assign wr_mod = {wd[MOD2_BIT], wd[MOD1_BIT], wd[MOD0_BIT]};

	// ----------------------------------------
	// counter stepping
	// ----------------------------------------
	wire step;
	wire wrap;

	assign step       = counter_run_control && count_tick_i;
	assign wrap       = step && (count == CNT_MAX);
	assign next_count = count + 16'h0001;

	// ----------------------------------------
	// run control
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			counter_run_control <= CTRL_RESET[RUN_BIT];
		end else if (wr_hit) begin
			counter_run_control <= wd[RUN_BIT];
		end
	end

	// ----------------------------------------
	// shared counter
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			count <= CNT_RESET;
		end else if (step) begin
			count <= next_count;
		end
	end

	// ----------------------------------------
	// sticky flags
	// ----------------------------------------
	// hardware set wins over a same-cycle software clear, so no event is lost
	cacf_flag_cell #(
		.RESET_VAL (CTRL_RESET[OVF_BIT])
	) cacf_flag_cell_i (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.set_i     (wrap),
		.wr_i      (wr_hit),
		.wdata_i   (wd[OVF_BIT]),
		.flag_o    (counter_overflow_flag)
	);

	for (genvar m = 0; m < 3; m++) begin : g_mod_flag
		cacf_flag_cell #(
			.RESET_VAL (CTRL_RESET[m])
		) cacf_flag_cell_i (
			.clk_i     (clk_i),
			.sys_rst_i (sys_rst_i),
			.set_i     (mod_event_i[m]),
			.wr_i      (wr_hit),
			.wdata_i   (wr_mod[m]),
			.flag_o    (module_event_flag[m])
		);
	end

	// ----------------------------------------
	// read-back
	// ----------------------------------------
	wire [7:0] status_rd;
	wire [7:0] next_rdata;

	assign status_rd[OVF_BIT]  = counter_overflow_flag;
	assign status_rd[RUN_BIT]  = counter_run_control;
	assign status_rd[5:3]      = 3'h0; // reserved reads zero
	assign status_rd[MOD2_BIT] = module_event_flag[2];
	assign status_rd[MOD1_BIT] = module_event_flag[1];
	assign status_rd[MOD0_BIT] = module_event_flag[0];
	// idle data is zero so a stray sample never shows stale status
	assign next_rdata          = rd_hit ? status_rd : 8'h00;

	// ----------------------------------------
	// interrupt request
	// ----------------------------------------
	wire ovf_req;
	wire mod_req;
	wire next_irq;

	assign ovf_req  = irq_en_i.ovf_ie && counter_overflow_flag;
	assign mod_req  = |(irq_en_i.mod_ie & module_event_flag);
	assign next_irq = ovf_req | mod_req;

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sfr_rdata_o <= 8'h00;
		end else begin
			sfr_rdata_o <= next_rdata;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sfr_rvalid_o <= 1'b0;
		end else begin
			sfr_rvalid_o <= rd_hit;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			counter_run_o <= 1'b0;
		end else begin
			counter_run_o <= counter_run_control;
		end
	end

	// one cycle behind the internal count, as is the wrap pulse
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			counter_value_o <= 16'h0000;
		end else begin
			counter_value_o <= count;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			counter_wrap_o <= 1'b0;
		end else begin
			counter_wrap_o <= wrap;
		end
	end

	// irq lags the flags by one cycle; the core must tolerate that
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= next_irq;
		end
	end
endmodule

// ----------------------------------------
// one sticky flag: hardware sets, software writes
// ----------------------------------------
module cacf_flag_cell #(
	parameter logic RESET_VAL = 1'b0
)
(
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	input  wire logic set_i,
	input  wire logic wr_i,
	input  wire logic wdata_i,
	output logic      flag_o
);
	wire next_flag;

	// set has priority over a write of zero in the same cycle
	assign next_flag = set_i | (wr_i ? wdata_i : flag_o);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			flag_o <= RESET_VAL;
		end else begin
			flag_o <= next_flag;
		end
	end
endmodule

/* dv/cacf_ctrl_checker.sv */
// Purpose: port assertions for cacf_ctrl
// Assumes: one clock, async reset
// Notes: bound by wildcard names
module cacf_ctrl_checker
	import cacf_pkg::*;
(
	input wire logic                    clk_i,
	input wire logic                    sys_rst_i,
	input wire cacf_pkg::cacf_sfr_req_t sfr_req_i,
	input wire cacf_pkg::cacf_irq_en_t  irq_en_i,
	input wire logic [2:0]              mod_event_i,
	input wire logic [7:0]              sfr_rdata_o,
	input wire logic                    sfr_rvalid_o,
	input wire logic                    counter_run_o,
	input wire logic [15:0]             counter_value_o,
	input wire logic                    counter_wrap_o,
	input wire logic                    irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	wire hit = sfr_req_i.addr == CTRL_ADDR;
	a_run_start: assert property (sfr_req_i.wr && hit && sfr_req_i.wdata[6] |-> ##2 counter_run_o)
		else $error("run bit not applied");
	a_event_irq: assert property (mod_event_i[0] && irq_en_i.mod_ie[0] ##1 irq_en_i.mod_ie[0] |=> irq_o)
		else $error("event did not raise irq");
	a_read_answer: assert property (sfr_req_i.rd && hit |=> sfr_rvalid_o)
		else $error("read not answered");
	a_rsvd_zero: assert property (sfr_rvalid_o |-> (sfr_rdata_o & RSVD_MASK) == 8'h00)
		else $error("reserved bits read nonzero");
	a_irq_cause: assert property (irq_o |-> $past(irq_en_i) != '0)
		else $error("irq without enable");
	// a flag may only fall after a software write
	a_flag_sticky: assert property (irq_o && !sfr_req_i.wr && !$past(sfr_req_i.wr) && $stable(irq_en_i) |=> irq_o)
		else $error("flag dropped without write");
	a_wrap_value: assert property (counter_wrap_o |-> counter_value_o == CNT_MAX)
		else $error("wrap not at counter maximum");
	a_ovf_irq: assert property (counter_wrap_o && irq_en_i.ovf_ie |=> irq_o)
		else $error("overflow did not raise irq");
endmodule
bind cacf_ctrl cacf_ctrl_checker cacf_ctrl_checker_i(.*);

/* dv/cacf_ctrl_bench.sv */
// Purpose: self-checking bench for cacf_ctrl
// Assumes: 20 MHz clock
// Notes: full 16-bit wrap is run, about 65k cycles
module cacf_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import cacf_pkg::*;
	logic clk_i = 0, sys_rst_i = 1, count_tick_i = 0, sfr_rvalid_o, counter_run_o;
	logic counter_wrap_o, irq_o;
	logic [2:0] mod_event_i = '0;
	logic [7:0] sfr_rdata_o;
	logic [15:0] counter_value_o, hold;
	bit timed_out = 1'b0;
	cacf_sfr_req_t sfr_req_i = '0;
	cacf_irq_en_t irq_en_i = '0;
	int error_cnt = 0, checks = 0;
	always #25 clk_i = ~clk_i;
	cacf_ctrl cacf_ctrl_i (
		.clk_i           (clk_i),
		.sys_rst_i       (sys_rst_i),
		.sfr_req_i       (sfr_req_i),
		.irq_en_i        (irq_en_i),
		.count_tick_i    (count_tick_i),
		.mod_event_i     (mod_event_i),
		.sfr_rdata_o     (sfr_rdata_o),
		.sfr_rvalid_o    (sfr_rvalid_o),
		.counter_run_o   (counter_run_o),
		.counter_value_o (counter_value_o),
		.counter_wrap_o  (counter_wrap_o),
		.irq_o           (irq_o)
	);
	task end_sim;
		if (error_cnt == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(string n, logic [15:0] e, logic [15:0] s);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	// one access; a read compares data in its answer cycle
	task acc(bit w, logic [7:0] a, logic [7:0] d);
		@(posedge clk_i) sfr_req_i <= '{w, !w, a, d};
		@(posedge clk_i) sfr_req_i <= '0;
		#1 if (!w) chk("rdata", d, sfr_rdata_o);
	endtask
	task t_wrap;
		acc(1, 8'hd8, 8'h40);
		@(posedge clk_i) begin
			count_tick_i <= 1'b1;
			irq_en_i     <= '{1'b1, 3'h0};
		end
		#1 chk("run", 16'h1, counter_run_o);
		for (int i = 0; i < 70000 && counter_wrap_o !== 1'b1; i++) @(negedge clk_i);
		if (counter_wrap_o !== 1'b1) begin
			error_cnt++;
			timed_out = 1'b1;
		end else begin
			chk("count", CNT_MAX, counter_value_o);
			acc(0, 8'hd8, 8'hc0);
			chk("irq", 16'h1, irq_o);
		end
	endtask
	task t_events;
		acc(1, 8'hd8, 8'h40);
		@(posedge clk_i) irq_en_i <= '1;
		@(posedge clk_i) mod_event_i <= 3'h7;
		@(posedge clk_i) mod_event_i <= 3'h0;
		acc(0, 8'hd8, 8'h47);
		chk("irq", 16'h1, irq_o);
		acc(1, 8'hd9, 8'h00);
		acc(0, 8'hd8, 8'h47);
		acc(1, 8'hd8, 8'h78);
		acc(0, 8'hd8, 8'h40);
		chk("irq", 16'h0, irq_o);
		@(posedge clk_i) begin
			mod_event_i <= 3'h1;
			sfr_req_i   <= '{1'b1, 1'b0, 8'hd8, 8'h40};
		end
		@(posedge clk_i) begin
			mod_event_i <= 3'h0;
			sfr_req_i   <= '0;
		end
		acc(0, 8'hd8, 8'h41);
		acc(1, 8'hd8, 8'h00);
		@(posedge clk_i);
		#1 hold = counter_value_o;
		repeat (3) @(posedge clk_i);
		#1 chk("hold", hold, counter_value_o);
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		acc(0, 8'hd8, 8'h00);
		t_wrap;
		if (!timed_out) t_events;
		end_sim;
	end
endmodule
